//--- hw/pcv_vectors.sv
// pcs/pma configuration and status vector block
//
// Operation
// - takes a 536-bit configuration vector and drives a 448-bit status vector
// - unassigned config bits ignored; emulated status bits show standard defaults
// - config pulse controls imitate set/clear-on-read; user drives them instead of reads
// - cfg 0 pma loopback, 16 tx disable async; cfg 110 pcs loopback clocked
// - seed a from cfg 169:112, seed b from cfg 233:176, clocked
// - cfg 240..245 select data, test pattern, checks, prbs31 tx and rx
// - cfg 399:384 is the async 125 us timer control
// - cfg 512 sets pma link latch; cfg 513 clears pma faults
// - cfg 516 sets pcs link latch; cfg 517 clears pcs faults
// - cfg 518 resets status-2 latches and counters; 519 test pattern counter
// - status 18 latching-low pma link; status 48 signal detect
// - status 42 and 43 pma rx and tx faults, latching high
// - status 23 and 231 are ors of the two fault latches
// - ability and device-responding bits are constants
// - status 226 latching-low pcs link; 250, 251 latching-high pcs faults
// - status 256 block lock, 257 high ber, 268 pcs link, live
// - errored blocks 279:272, ber 285:280, latched ber 286, lock 287
// - test pattern error counter on status 303:288
// - status 15 echoes pma reset; 223 echoes pcs reset on older parts
`timescale 1ns/1ps
`default_nettype none
module pcv_vectors
   import pcv_pkg::*;
#(
   parameter bit          PCS_RST_ECHO = 1'b1,
   parameter logic [15:0] VERSION      = VERSION_RST
) (
   // clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_b_i,
   // management vectors
   input  wire logic [CFG_W-1:0]     cfg_vector_i,
   output logic      [STAT_W-1:0]    status_vector_o,
   // live conditions from the pcs/pma
   input  wire logic                 pma_link_i,
   input  wire logic                 signal_detect_i,
   input  wire logic                 pma_rx_fault_i,
   input  wire logic                 pma_tx_fault_i,
   input  wire logic                 pcs_link_i,
   input  wire logic                 pcs_rx_fault_i,
   input  wire logic                 pcs_tx_fault_i,
   input  wire logic                 block_lock_i,
   input  wire logic                 hi_ber_i,
   input  wire logic                 errored_block_i,
   input  wire logic                 ber_event_i,
   input  wire logic                 tp_error_i,
   // controls to the pcs/pma
   output logic                      pma_loopback_o,
   output logic                      pmd_tx_disable_o,
   output logic                      pcs_loopback_o,
   output logic                      pma_reset_o,
   output logic                      pcs_reset_o,
   output logic      [SEED_W-1:0]    seed_a_o,
   output logic      [SEED_W-1:0]    seed_b_o,
   output logic      [TP_W-1:0]      test_pattern_ctrl_o,
   output logic      [TIMER_W-1:0]   timer_ctrl_o
);
   // ==========================================
   // elaboration check
   if (CFG_W != 536 || STAT_W != 448)
   begin : g_bad_w
      $error("vector widths do not match the bit map");
   end

   // ==========================================
   // counter links
   pcv_cnt_if #(.W(ERR_BLK_W)) err_blk_c ();
   pcv_cnt_if #(.W(BER_W))     ber_c     ();
   pcv_cnt_if #(.W(TP_ERR_W))  tp_err_c  ();

   logic pma_ls;
   logic pma_rxf;
   logic pma_txf;
   logic pcs_ls;
   logic pcs_rxf;
   logic pcs_txf;
   logic lh_hi_ber;
   logic ll_lock;
   logic sig_det;
   logic lock_live;
   logic hi_ber_live;
   logic pcs_live;

   // ==========================================
   // asynchronous controls pass straight through
   assign pma_loopback_o   = cfg_vector_i[C_PMA_LOOP];
   assign pmd_tx_disable_o = cfg_vector_i[C_TX_DIS];
   assign timer_ctrl_o     = cfg_vector_i[C_TIMER_LO +: TIMER_W];

   // ==========================================
   // clocked controls
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         pcs_loopback_o      <= 1'b0;
         seed_a_o            <= '0;
         seed_b_o            <= '0;
         test_pattern_ctrl_o <= '0;
      end
      else
      begin
         pcs_loopback_o      <= cfg_vector_i[C_PCS_LOOP];
         seed_a_o            <= cfg_vector_i[C_SEED_A_LO +: SEED_W];
         seed_b_o            <= cfg_vector_i[C_SEED_B_LO +: SEED_W];
         test_pattern_ctrl_o <= cfg_vector_i[C_TP_LO +: TP_W];
      end
   end

   // resets are forwarded as given; the user keeps them to one cycle
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         pma_reset_o <= 1'b0;
         pcs_reset_o <= 1'b0;
      end
      else
      begin
         pma_reset_o <= cfg_vector_i[C_PMA_RST];
         pcs_reset_o <= cfg_vector_i[C_PCS_RST];
      end
   end

   // ==========================================
   // live status sampled on the core clock
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         sig_det     <= 1'b0;
         lock_live   <= 1'b0;
         hi_ber_live <= 1'b0;
         pcs_live    <= 1'b0;
      end
      else
      begin
         sig_det     <= signal_detect_i;
         lock_live   <= block_lock_i;
         hi_ber_live <= hi_ber_i;
         pcs_live    <= pcs_link_i;
      end
   end

   // ==========================================
   // pma/pmd latches
   // a set pulse reloads from the live level, so a loss in that
   // same cycle is never hidden
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
         pma_ls <= 1'b0;
      else if (cfg_vector_i[C_SET_PMA_LS])
         pma_ls <= pma_link_i;
      else
         pma_ls <= pma_ls & pma_link_i;
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         pma_rxf <= 1'b0;
         pma_txf <= 1'b0;
      end
      else if (cfg_vector_i[C_CLR_PMA_F])
      begin
         pma_rxf <= pma_rx_fault_i;
         pma_txf <= pma_tx_fault_i;
      end
      else
      begin
         pma_rxf <= pma_rxf | pma_rx_fault_i;
         pma_txf <= pma_txf | pma_tx_fault_i;
      end
   end

   // ==========================================
   // pcs latches
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
         pcs_ls <= 1'b0;
      else if (cfg_vector_i[C_SET_PCS_LS])
         pcs_ls <= pcs_link_i;
      else
         pcs_ls <= pcs_ls & pcs_link_i;
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         pcs_rxf <= 1'b0;
         pcs_txf <= 1'b0;
      end
      else if (cfg_vector_i[C_CLR_PCS_F])
      begin
         pcs_rxf <= pcs_rx_fault_i;
         pcs_txf <= pcs_tx_fault_i;
      end
      else
      begin
         pcs_rxf <= pcs_rxf | pcs_rx_fault_i;
         pcs_txf <= pcs_txf | pcs_tx_fault_i;
      end
   end

   // ==========================================
   // status 2 latches, cleared together with its counters
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         lh_hi_ber <= 1'b0;
         ll_lock   <= 1'b0;
      end
      else if (cfg_vector_i[C_RST_ST2])
      begin
         lh_hi_ber <= hi_ber_i;
         ll_lock   <= block_lock_i;
      end
      else
      begin
         lh_hi_ber <= lh_hi_ber | hi_ber_i;
         ll_lock   <= ll_lock & block_lock_i;
      end
   end

   // ==========================================
   // counters
   assign err_blk_c.inc = errored_block_i;
   assign err_blk_c.clr = cfg_vector_i[C_RST_ST2];
   assign ber_c.inc     = ber_event_i;
   assign ber_c.clr     = cfg_vector_i[C_RST_ST2];
   assign tp_err_c.inc  = tp_error_i;
   assign tp_err_c.clr  = cfg_vector_i[C_RST_TPCNT];

   pcv_sat_cnt #(.W(ERR_BLK_W)) u_err_blk (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .c       (err_blk_c)
   );

   pcv_sat_cnt #(.W(BER_W)) u_ber (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .c       (ber_c)
   );

   pcv_sat_cnt #(.W(TP_ERR_W)) u_tp_err (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .c       (tp_err_c)
   );

   // ==========================================
   // status vector assembly
   // bits outside the map read as zero
   always_comb
   begin
      status_vector_o = '0;
      for (int i = 0; i < N_CONST; i++)
         status_vector_o[S_CONST_ONES[i]] = 1'b1;
      status_vector_o[S_VER_LO +: 16]   = VERSION;
      status_vector_o[S_PMA_RST]        = pma_reset_o;
      status_vector_o[S_PCS_RST]        = PCS_RST_ECHO & pcs_reset_o;
      status_vector_o[S_PMA_LS]         = pma_ls;
      status_vector_o[S_PMA_RXF]        = pma_rxf;
      status_vector_o[S_PMA_TXF]        = pma_txf;
      status_vector_o[S_PMA_FLT]        = pma_rxf | pma_txf;
      status_vector_o[S_SIG_DET]        = sig_det;
      status_vector_o[S_PCS_LS]         = pcs_ls;
      status_vector_o[S_PCS_RXF]        = pcs_rxf;
      status_vector_o[S_PCS_TXF]        = pcs_txf;
      status_vector_o[S_PCS_FLT]        = pcs_rxf | pcs_txf;
      status_vector_o[S_BLK_LOCK]       = lock_live;
      status_vector_o[S_HI_BER]         = hi_ber_live;
      status_vector_o[S_PCS_LIVE]       = pcs_live;
      status_vector_o[S_ERR_BLK_LO +: ERR_BLK_W] = err_blk_c.value;
      status_vector_o[S_BER_LO +: BER_W]         = ber_c.value;
      status_vector_o[S_LH_HI_BER]      = lh_hi_ber;
      status_vector_o[S_LL_LOCK]        = ll_lock;
      status_vector_o[S_TP_ERR_LO +: TP_ERR_W]   = tp_err_c.value;
   end

   // ==========================================
   // assertions
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   sequence s_pcs_set_up;
      cfg_vector_i[C_SET_PCS_LS] && pcs_link_i;
   endsequence

   sequence s_pcs_stay_up;
      !cfg_vector_i[C_SET_PCS_LS] && pcs_link_i;
   endsequence

   AST_PCS_LOOP: assert property (
      $past(rst_b_i) |-> pcs_loopback_o == $past(cfg_vector_i[C_PCS_LOOP]))
      else $error("pcs loopback not following its config bit");

   AST_PMA_LINK_LOW: assert property (
      !pma_link_i |=> !status_vector_o[S_PMA_LS])
      else $error("pma link latch missed a loss");

   AST_PCS_SET_HOLD: assert property (
      s_pcs_set_up ##1 s_pcs_stay_up |=> status_vector_o[S_PCS_LS])
      else $error("pcs link latch not reloaded or not held");

   AST_PMA_RXF_HIGH: assert property (
      pma_rx_fault_i |=> status_vector_o[S_PMA_RXF] ##1
      (status_vector_o[S_PMA_RXF] || $past(cfg_vector_i[C_CLR_PMA_F])))
      else $error("pma rx fault not latched");

   AST_FAULT_OR: assert property (
      status_vector_o[S_PCS_FLT] ==
      (status_vector_o[S_PCS_RXF] | status_vector_o[S_PCS_TXF]))
      else $error("pcs fault is not the or of its latches");

   AST_CONST_BITS: assert property (
      status_vector_o[47] && status_vector_o[32] && status_vector_o[255])
      else $error("constant ability bit dropped");

   AST_PCS_CLR_FLT: assert property (
      cfg_vector_i[C_CLR_PCS_F] && !pcs_rx_fault_i |=> !status_vector_o[S_PCS_RXF])
      else $error("pcs rx fault not cleared");

   AST_TP_CLR: assert property (
      cfg_vector_i[C_RST_TPCNT] && !tp_error_i
      |=> status_vector_o[S_TP_ERR_LO +: TP_ERR_W] == '0)
      else $error("test pattern counter not cleared");

   AST_LOCK_LIVE: assert property (
      block_lock_i |=> status_vector_o[S_BLK_LOCK])
      else $error("block lock not reported");

   AST_PMA_RST_ECHO: assert property (
      cfg_vector_i[C_PMA_RST] |=> status_vector_o[S_PMA_RST] ##1
      (status_vector_o[S_PMA_RST] == $past(cfg_vector_i[C_PMA_RST])))
      else $error("pma reset echo wrong");
endmodule
`default_nettype wire

//--- shared/pcv_pkg.sv
// constants for the pcs/pma configuration and status vectors
`default_nettype none
package pcv_pkg;
   // ==========================================
   // vector widths
   localparam int CFG_W  = 536;
   localparam int STAT_W = 448;
   // ==========================================
   // configuration bit positions
   localparam int C_PMA_LOOP   = 0;
   localparam int C_PMA_RST    = 15;
   localparam int C_TX_DIS     = 16;
   localparam int C_PCS_LOOP   = 110;
   localparam int C_PCS_RST    = 111;
   localparam int C_SEED_A_LO  = 112;
   localparam int C_SEED_B_LO  = 176;
   localparam int SEED_W       = 58;
   localparam int C_TP_LO      = 240;
   localparam int TP_W         = 6;
   localparam int C_TIMER_LO   = 384;
   localparam int TIMER_W      = 16;
   localparam int C_SET_PMA_LS = 512;
   localparam int C_CLR_PMA_F  = 513;
   localparam int C_SET_PCS_LS = 516;
   localparam int C_CLR_PCS_F  = 517;
   localparam int C_RST_ST2    = 518;
   localparam int C_RST_TPCNT  = 519;
   // ==========================================
   // status bit positions
   localparam int S_PMA_RST    = 15;
   localparam int S_PMA_LS     = 18;
   localparam int S_PMA_FLT    = 23;
   localparam int S_PMA_RXF    = 42;
   localparam int S_PMA_TXF    = 43;
   localparam int S_SIG_DET    = 48;
   localparam int S_VER_LO     = 192;
   localparam int S_PCS_RST    = 223;
   localparam int S_PCS_LS     = 226;
   localparam int S_PCS_FLT    = 231;
   localparam int S_PCS_RXF    = 250;
   localparam int S_PCS_TXF    = 251;
   localparam int S_BLK_LOCK   = 256;
   localparam int S_HI_BER     = 257;
   localparam int S_PCS_LIVE   = 268;
   localparam int S_ERR_BLK_LO = 272;
   localparam int S_BER_LO     = 280;
   localparam int S_LH_HI_BER  = 286;
   localparam int S_LL_LOCK    = 287;
   localparam int S_TP_ERR_LO  = 288;
   // constant ability bits; the first N_CONST read as one, the last entry (0) is unused
   localparam int S_CONST_ONES [9] = '{32, 40, 44, 45, 47, 240, 255, 258, 0};
   localparam int N_CONST      = 8;
   // ==========================================
   // counter widths and reset values
   localparam int ERR_BLK_W    = 8;
   localparam int BER_W        = 6;
   localparam int TP_ERR_W     = 16;
   localparam logic [15:0] VERSION_RST = 16'h0001; // arbitrary value
endpackage
`default_nettype wire

//--- shared/pcv_cnt_if.sv
// saturating counter link between the vector block and its counters
`timescale 1ns/1ps
`default_nettype none
interface pcv_cnt_if #(parameter int W = 8);
   logic         inc;
   logic         clr;
   logic [W-1:0] value;
   modport cnt  (input inc, input clr, output value);
   modport user (output inc, output clr, input value);
endinterface
`default_nettype wire

//--- hw/pcv_sat_cnt.sv
// saturating event counter with synchronous clear
`timescale 1ns/1ps
`default_nettype none
module pcv_sat_cnt #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   // counter link
   pcv_cnt_if.cnt    c
);
   // ==========================================
   // elaboration check
   // the clear-with-event path needs at least one padding bit
   if (W < 2 || W > 32)
   begin : g_bad_w
      $error("counter width out of range");
   end

   // ==========================================
   // counter
   // an event in the clearing cycle counts as the first one
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
         c.value <= '0;
      else if (c.clr)
         c.value <= {{(W-1){1'b0}}, c.inc};
      else if (c.inc && !(&c.value))
         c.value <= c.value + {{(W-1){1'b0}}, 1'b1};
   end
endmodule
`default_nettype wire

//--- verification/pcv_user_model.sv
// user management logic model driving the configuration vector
`timescale 1ns/1ps
`default_nettype none
module pcv_user_model
   import pcv_pkg::*;
(
   // clock
   input  wire logic             clk_i,
   // configuration vector
   output logic      [CFG_W-1:0] cfg_o
);
   // ==========================================
   // level settings
   initial cfg_o = '0;

   // set w bits from lo, changed just after an edge by the caller
   task automatic set_bits(input int lo, input int w, input logic [63:0] v);
      for (int i = 0; i < w; i++)
         cfg_o[lo+i] = v[i];
   endtask

   // ==========================================
   // pulse controls
   // stands in for a register read or a reset write: high one edge only
   task automatic pulse(input int b);
      @(posedge clk_i);
      #1;
      cfg_o[b] = 1'b1;
      @(posedge clk_i);
      #1;
      cfg_o[b] = 1'b0;
   endtask
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// self-checking testbench for the configuration and status vector block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import pcv_pkg::*;
   // ==========================================
   // signals
   logic                clk_i = 1'b0;
   logic                rst_b_i = 1'b0;
   logic [CFG_W-1:0]    cfg;
   logic [STAT_W-1:0]   st;
   logic [1:0]          lnk = '0;
   logic [3:0]          flt = '0;
   logic                sig_det = 1'b0;
   logic                lock = 1'b0;
   logic                hi_ber = 1'b0;
   logic                eb = 1'b0;
   logic                be = 1'b0;
   logic                tpe = 1'b0;
   logic                pma_lb, tx_dis, pcs_lb, pma_rst, pcs_rst;
   logic [SEED_W-1:0]   sa, sb;
   logic [TP_W-1:0]     tp;
   logic [TIMER_W-1:0]  tmr;
   int                  errors = 0;
   int                  n_checks = 0;
   int                  cyc = 0;

   initial forever #5 clk_i = ~clk_i;

   pcv_user_model u_user (.clk_i(clk_i), .cfg_o(cfg));

   pcv_vectors DUT (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .cfg_vector_i(cfg), .status_vector_o(st),
      .pma_link_i(lnk[0]), .signal_detect_i(sig_det), .pma_rx_fault_i(flt[0]),
      .pma_tx_fault_i(flt[1]), .pcs_link_i(lnk[1]), .pcs_rx_fault_i(flt[2]),
      .pcs_tx_fault_i(flt[3]), .block_lock_i(lock), .hi_ber_i(hi_ber),
      .errored_block_i(eb), .ber_event_i(be), .tp_error_i(tpe),
      .pma_loopback_o(pma_lb), .pmd_tx_disable_o(tx_dis), .pcs_loopback_o(pcs_lb),
      .pma_reset_o(pma_rst), .pcs_reset_o(pcs_rst), .seed_a_o(sa), .seed_b_o(sb),
      .test_pattern_ctrl_o(tp), .timer_ctrl_o(tmr));

   // ==========================================
   // helpers
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wrap_up;
      if (errors == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // hang guard: the sequence needs about 150 cycles
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         errors++;
         wrap_up();
      end
   end

   // ==========================================
   // scenarios
   task automatic t_reset_values;
      for (int k = 0; k < N_CONST; k++)
         chk(st[S_CONST_ONES[k]], 1);
      chk(st[S_VER_LO+:16], VERSION_RST);
      chk({st[S_PMA_LS], st[S_PCS_LS], st[S_PMA_FLT], st[S_PCS_FLT]}, 0);
      chk({st[S_ERR_BLK_LO+:14], st[S_TP_ERR_LO+:16]}, 0);
   endtask

   task automatic t_controls;
      chk({pma_lb, tx_dis, tmr}, 0);
      u_user.set_bits(C_PMA_LOOP, 1, 1);
      u_user.set_bits(C_TX_DIS, 1, 1);
      u_user.set_bits(C_TIMER_LO, TIMER_W, 16'hc35a);
      u_user.set_bits(C_PCS_LOOP, 1, 1);
      u_user.set_bits(C_SEED_A_LO, SEED_W, 58'h1234_5678_9abc_def);
      u_user.set_bits(C_SEED_B_LO, SEED_W, 58'h2fed_cba9_8765_431);
      u_user.set_bits(1, 1, 1);
      u_user.set_bits(535, 1, 1);
      #1;
      chk({pma_lb, tx_dis, tmr}, {2'b11, 16'hc35a});
      chk(pcs_lb, 0);
      step(1);
      chk(pcs_lb, 1);
      chk(sa, 58'h1234_5678_9abc_def);
      chk(sb, 58'h2fed_cba9_8765_431);
      chk({st[S_PMA_LS], st[S_PMA_RST], st[S_PCS_RST]}, 0);
      for (int k = 0; k < TP_W; k++)
      begin
         u_user.set_bits(C_TP_LO, TP_W, 64'h1 << k);
         step(1);
         chk(tp, 64'h1 << k);
      end
      u_user.pulse(C_PMA_RST);
      chk({pma_rst, st[S_PMA_RST]}, 2'b11);
      step(1);
      chk({pma_rst, st[S_PMA_RST]}, 0);
      u_user.pulse(C_PCS_RST);
      chk({pcs_rst, st[S_PCS_RST]}, 2'b11);
      step(1);
      chk({pcs_rst, st[S_PCS_RST]}, 0);
   endtask

   task automatic t_links;
      int lpos[2] = '{S_PMA_LS, S_PCS_LS};
      int lset[2] = '{C_SET_PMA_LS, C_SET_PCS_LS};
      for (int i = 0; i < 2; i++)
      begin
         lnk[i] = 1'b1;
         step(2);
         chk(st[lpos[i]], 0);
         u_user.pulse(lset[i]);
         chk(st[lpos[i]], 1);
         lnk[i] = 1'b0;
         step(1);
         lnk[i] = 1'b1;
         step(2);
         chk(st[lpos[i]], 0);
         u_user.pulse(lset[i]);
         chk(st[lpos[i]], 1);
      end
      chk(st[S_PCS_LIVE], 1);
      {sig_det, lock, hi_ber} = 3'b111;
      step(1);
      chk({st[S_SIG_DET], st[S_BLK_LOCK], st[S_HI_BER]}, 3'b111);
      {sig_det, lock, hi_ber, lnk[1]} = 4'b0000;
      step(1);
      chk({st[S_SIG_DET], st[S_BLK_LOCK], st[S_HI_BER], st[S_PCS_LIVE]}, 0);
   endtask

   task automatic t_faults;
      int fpos[4] = '{S_PMA_RXF, S_PMA_TXF, S_PCS_RXF, S_PCS_TXF};
      int fclr[4] = '{C_CLR_PMA_F, C_CLR_PMA_F, C_CLR_PCS_F, C_CLR_PCS_F};
      int opos;
      for (int i = 0; i < 4; i++)
      begin
         opos = (i < 2) ? S_PMA_FLT : S_PCS_FLT;
         flt[i] = 1'b1;
         step(1);
         flt[i] = 1'b0;
         step(2);
         chk({st[fpos[i]], st[fpos[i^1]], st[opos]}, 3'b101);
         u_user.pulse(fclr[i]);
         chk({st[fpos[i]], st[opos]}, 0);
      end
      flt[0] = 1'b1;
      u_user.pulse(C_CLR_PMA_F);
      chk(st[S_PMA_RXF], 1);
      flt[0] = 1'b0;
      u_user.pulse(C_CLR_PMA_F);
      chk(st[S_PMA_RXF], 0);
   endtask

   task automatic t_counters;
      eb = 1'b1;
      step(3);
      eb = 1'b0;
      be = 1'b1;
      step(70);
      be = 1'b0;
      tpe = 1'b1;
      step(5);
      tpe = 1'b0;
      chk(st[S_ERR_BLK_LO+:ERR_BLK_W], 3);
      chk(st[S_BER_LO+:BER_W], 63);
      chk(st[S_TP_ERR_LO+:TP_ERR_W], 5);
      {hi_ber, lock} = 2'b10;
      u_user.pulse(C_RST_ST2);
      chk(st[S_ERR_BLK_LO+:14], 0);
      chk({st[S_LH_HI_BER], st[S_LL_LOCK]}, 2'b10);
      chk(st[S_TP_ERR_LO+:TP_ERR_W], 5);
      {hi_ber, lock} = 2'b01;
      step(2);
      chk({st[S_LH_HI_BER], st[S_LL_LOCK]}, 2'b10);
      u_user.pulse(C_RST_ST2);
      chk({st[S_LH_HI_BER], st[S_LL_LOCK]}, 2'b01);
      tpe = 1'b1;
      u_user.pulse(C_RST_TPCNT);
      tpe = 1'b0;
      chk(st[S_TP_ERR_LO+:TP_ERR_W], 1);
      u_user.pulse(C_RST_TPCNT);
      chk(st[S_TP_ERR_LO+:TP_ERR_W], 0);
   endtask

   // reset in mid-run drops the latches and registered controls
   task automatic t_mid_reset;
      chk({st[S_PMA_LS], pcs_lb}, 2'b11);
      rst_b_i = 1'b0;
      step(2);
      chk({st[S_PMA_LS], pcs_lb, st[S_CONST_ONES[0]]}, 3'b001);
      rst_b_i = 1'b1;
      step(1);
      chk({st[S_PMA_LS], pcs_lb}, 2'b01);
   endtask

   // ==========================================
   // main sequence
   initial
   begin
      step(4);
      t_reset_values();
      rst_b_i = 1'b1;
      step(1);
      t_controls();
      t_links();
      t_faults();
      t_counters();
      t_mid_reset();
      wrap_up();
   end
endmodule
`default_nettype wire
